//--- design/socket_pwr_defs.svh
// Offsets, field positions, reset values and timing counts of the socket power/clock control block.
// Assumes byte addressing on a 32-bit Avalon-MM slave port.
`ifndef SOCKET_PWR_DEFS_SVH
`define SOCKET_PWR_DEFS_SVH

// ==========================================================
// Register byte offsets
`define OFS_FORCE_EVENT   6'h0C
`define OFS_SUPPLY_CTRL   6'h10
`define OFS_CLOCK_PM      6'h20
`define OFS_EVT_STATUS    6'h30
`define OFS_EVT_CLEAR     6'h34
`define OFS_EVT_ENABLE    6'h38

// ==========================================================
// Field positions
`define CTRL_POLICY_BIT   7
`define CTRL_VCC_LSB      4
`define CTRL_VPP_LSB      0
`define PM_ACCESS_BIT     25
`define PM_RATE_BIT       24
`define PM_GATE_EN_BIT    16
`define PM_SLOW_SEL_BIT   0
`define FORCE_RETEST_BIT  14
`define FORCE_CAP_LSB     10

// ==========================================================
// Supply codes
`define SUP_OFF           3'h0
`define SUP_12V           3'h1
`define SUP_5V            3'h2
`define SUP_3V3           3'h3
`define SUP_XV            3'h4
`define SUP_YV            3'h5

// ==========================================================
// Reset values
`define RST_SUPPLY        3'h0
`define RST_EVT           3'h0

// ==========================================================
// Timing
`define CORE_PERIOD_NS    5
`define CB_PERIOD_NS      160
`define CB_NOMINAL_CYC    (`CB_PERIOD_NS / `CORE_PERIOD_NS)
`define CB_CHANGED_CYC    9'((4 * `CB_NOMINAL_CYC))

`endif

//--- design/socket_pwr_pkg.sv
// Types shared by the socket power/clock control block.
// Assumes socket_pwr_defs.svh supplies the offsets, field positions and codes; the bus and clock state encodings are set here.
package socket_pwr_pkg;

	typedef struct packed
	{
		logic       card_clock_stop_policy;
		logic [2:0] card_supply_request;
		logic [2:0] prog_supply_request;
	} supply_ctrl_t;

	typedef struct packed
	{
		logic clock_gate_enable;
		logic clock_stop_or_slow_select;
	} clock_pm_t;

	typedef struct packed
	{
		logic yv;
		logic xv;
		logic v3;
		logic v5;
	} card_caps_t;

	typedef struct packed
	{
		logic bad_request;
		logic rate_change;
		logic access;
	} evt_t;

	typedef struct packed
	{
		logic       card_clk;
		logic       card_access;
		logic       socket_idle;
		logic       host_stop_prep;
		card_caps_t caps;
	} pins_t;

	typedef enum logic [1:0]
	{
		BUS_WAIT = 2'h1,
		BUS_DONE = 2'h2
	} bus_state_t;

	typedef enum logic [2:0]
	{
		CLK_RUN  = 3'h1,
		CLK_STOP = 3'h2,
		CLK_SLOW = 3'h4
	} clk_state_t;

	typedef struct packed
	{
		bus_state_t   bus;
		logic [31:0]  rdata;
		supply_ctrl_t ctrl;
		logic         ctrl_enable;
		card_caps_t   caps;
		clock_pm_t    pm;
		logic         access_flag;
		logic         access_prev;
		logic         rate_prev;
		logic         bad_prev;
		evt_t         evt_status;
		evt_t         evt_enable;
		logic         irq;
		clk_state_t   clk;
		logic [2:0]   vcc_apply;
		logic [2:0]   vpp_apply;
	} state_t;

endpackage

//--- design/pin_sync.sv
// Two-flop synchroniser for a group of asynchronous pins.
// Assumes the pins are quasi-static relative to the core clock.
`timescale 1ns/100ps
module pin_sync
	import socket_pwr_pkg::*;
#(
	parameter int W = 1
)
(
	input  wire logic         clk,
	input  wire logic         rst_b,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	typedef struct packed
	{
		logic [W-1:0] meta_ff;
		logic [W-1:0] sync_ff;
	} sync_t;

	sync_t st_ff;
	sync_t nxt_st;

	always_comb
	begin
		nxt_st.meta_ff = din;
		nxt_st.sync_ff = st_ff.meta_ff;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	assign dout = st_ff.sync_ff;
endmodule // pin_sync

//--- design/cb_clock_monitor.sv
// Measures the card clock period in core cycles and flags a changed rate.
// Assumes the card clock input is already synchronised to the core clock.
`timescale 1ns/100ps
`include "socket_pwr_defs.svh"
module cb_clock_monitor
	import socket_pwr_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst_b,
	input  wire logic cb_clk_sync,
	output logic      rate_changed
);
	typedef struct packed
	{
		logic       prev;
		logic [8:0] cnt;
		logic       changed;
	} mon_t;

	mon_t st_ff;
	mon_t nxt_st;

	always_comb
	begin
		nxt_st      = st_ff;
		nxt_st.prev = cb_clk_sync;
		if (cb_clk_sync && !st_ff.prev)
		begin
			// A full period has been seen: judge it
			nxt_st.changed = (st_ff.cnt >= `CB_CHANGED_CYC);
			nxt_st.cnt     = 9'h001;
		end
		else if (st_ff.cnt != 9'h1FF)
		begin
			nxt_st.cnt = st_ff.cnt + 9'h001;
		end
		// A stopped clock never gives an edge, so the running count must also flag it
		if (st_ff.cnt >= `CB_CHANGED_CYC)
			nxt_st.changed = 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	assign rate_changed = st_ff.changed;
endmodule // cb_clock_monitor

//--- design/socket_power_clock_control.sv
// Socket supply and card clock power management registers on an Avalon-MM slave.
// Assumes socket pins are asynchronous to CORE_CLK and a host master that honours waitrequest.
// Rails leave as supply codes for an external power switch; the card clock itself is gated outside.
//
// Contract
// - Socket control bits 31..8 and 3 read zero; writes there are ignored.
// - Policy 0: reduce card clock only if socket idle and host clock stop is prepared.
// - Policy 1: reduce card clock whenever the socket is idle.
// - Card supply field 6..4: off, 5V, 3.3V, X.X, Y.Y; 001, 110, 111 reserved.
// - Programming supply field 2..0: off, 12V, 5V, 3.3V, X.X, Y.Y; 110, 111 reserved.
// - Apply only supplies the card accepts; refuse unacceptable requests.
// - Power management bits 31..26, 23..17, 15..1 read zero; writes ignored.
// - Access flag bit 25 sets on card access, clears on register read, resets zero.
// - Bit 24 reads 1 when card clock rate changed, 0 when normal.
// - Bit 16 gates the stop-or-slow select; select acts only while it is 1.
// - Select bit 0: 0 stops the card clock, 1 slows it by sixteen.
// - Writing the retest bit re-reads card capability and re-enables socket control.
// - Writing any force-capability bit disables socket control until a retest.
`timescale 1ns/100ps
`include "socket_pwr_defs.svh"
module socket_power_clock_control
	import socket_pwr_pkg::*;
(
	input  wire logic        CORE_CLK,
	input  wire logic        RST_B,
	input  wire logic [5:0]  AVS_ADDRESS,
	input  wire logic        AVS_READ,
	input  wire logic        AVS_WRITE,
	input  wire logic [31:0] AVS_WRITEDATA,
	input  wire logic [3:0]  AVS_BYTEENABLE,
	output logic      [31:0] AVS_READDATA,
	output logic             AVS_WAITREQUEST,
	input  wire logic        CARD_CLK,
	input  wire logic        CARD_ACCESS,
	input  wire logic        SOCKET_IDLE,
	input  wire logic        HOST_CLK_STOP_PREP,
	input  wire logic [3:0]  CARD_CAPS,
	output logic      [2:0]  VCC_APPLY,
	output logic      [2:0]  VPP_APPLY,
	output logic             CARD_CLK_STOP,
	output logic             CARD_CLK_SLOW,
	output logic             IRQ
);

	// ==========================================================
	// Pin synchronisers and card clock monitor
	pins_t pins;
	logic  rate_changed;

	pin_sync #(.W($bits(pins_t))) u_sync
	(
		.clk   (CORE_CLK),
		.rst_b (RST_B),
		.din   ({CARD_CLK, CARD_ACCESS, SOCKET_IDLE, HOST_CLK_STOP_PREP, CARD_CAPS}),
		.dout  (pins)
	);

	cb_clock_monitor u_mon
	(
		.clk          (CORE_CLK),
		.rst_b        (RST_B),
		.cb_clk_sync  (pins.card_clk),
		.rate_changed (rate_changed)
	);

	// ==========================================================
	// Supply acceptance
	function automatic logic vcc_ok(input logic [2:0] code, input card_caps_t c);
		logic ok;
		ok = 1'b0;
		unique case (code)
			`SUP_OFF: ok = 1'b1;
			`SUP_5V:  ok = c.v5;
			`SUP_3V3: ok = c.v3;
			`SUP_XV:  ok = c.xv;
			`SUP_YV:  ok = c.yv;
			default:  ok = 1'b0; // Reserved codes are refused
		endcase
		return ok;
	endfunction

	function automatic logic vpp_ok(input logic [2:0] code, input card_caps_t c);
		logic ok;
		ok = 1'b0;
		unique case (code)
			`SUP_OFF: ok = 1'b1;
			`SUP_12V: ok = c.v5 | c.v3;
			`SUP_5V:  ok = c.v5;
			`SUP_3V3: ok = c.v3;
			`SUP_XV:  ok = c.xv;
			`SUP_YV:  ok = c.yv;
			default:  ok = 1'b0;
		endcase
		return ok;
	endfunction

	// ==========================================================
	// State
	state_t st_ff;
	state_t nxt_st;

	logic        req;
	logic        take;
	logic        wr;
	logic        rd;
	logic [31:0] rd_val;
	logic        ok_vcc;
	logic        ok_vpp;
	logic        bad;
	logic        reduce_ok;
	logic        slow_sel;
	evt_t        evt_set;
	evt_t        evt_clr;

	always_comb
	begin
		nxt_st    = st_ff;
		req       = AVS_READ | AVS_WRITE;
		take      = req && (st_ff.bus == BUS_DONE);
		wr        = take && AVS_WRITE;
		rd        = take && AVS_READ;
		rd_val    = 32'h0000_0000;
		evt_clr   = '0;
		ok_vcc    = vcc_ok(st_ff.ctrl.card_supply_request, st_ff.caps);
		ok_vpp    = vpp_ok(st_ff.ctrl.prog_supply_request, st_ff.caps);
		bad       = st_ff.ctrl_enable && !(ok_vcc && ok_vpp);

		// ==========================================================
		// Read mux; unused bits stay zero
		unique case (AVS_ADDRESS)
			`OFS_SUPPLY_CTRL:
			begin
				rd_val[`CTRL_POLICY_BIT]                 = st_ff.ctrl.card_clock_stop_policy;
				rd_val[`CTRL_VCC_LSB +: 3]               = st_ff.ctrl.card_supply_request;
				rd_val[`CTRL_VPP_LSB +: 3]               = st_ff.ctrl.prog_supply_request;
			end
			`OFS_CLOCK_PM:
			begin
				rd_val[`PM_ACCESS_BIT]   = st_ff.access_flag;
				rd_val[`PM_RATE_BIT]     = rate_changed;
				rd_val[`PM_GATE_EN_BIT]  = st_ff.pm.clock_gate_enable;
				rd_val[`PM_SLOW_SEL_BIT] = st_ff.pm.clock_stop_or_slow_select;
			end
			`OFS_EVT_STATUS: rd_val[2:0] = st_ff.evt_status;
			`OFS_EVT_ENABLE: rd_val[2:0] = st_ff.evt_enable;
			default:         rd_val      = 32'h0000_0000;
		endcase

		// ==========================================================
		// Bus handshake: decode one cycle, answer with waitrequest low the next
		unique case (st_ff.bus)
			BUS_WAIT:
			begin
				if (req)
				begin
					nxt_st.bus   = BUS_DONE;
					nxt_st.rdata = rd_val;
				end
			end
			BUS_DONE:
			begin
				nxt_st.bus   = BUS_WAIT;
				nxt_st.rdata = 32'h0000_0000;
			end
			default:
			begin
				// Codes 00 and 11 only follow an upset; fall back to idle
				nxt_st.bus   = BUS_WAIT;
				nxt_st.rdata = 32'h0000_0000;
			end
		endcase

		// ==========================================================
		// Register writes take effect only on the accepting edge
		if (wr)
		begin
			unique case (AVS_ADDRESS)
				`OFS_SUPPLY_CTRL:
				begin
					// A disabled control register ignores software
					if (st_ff.ctrl_enable && AVS_BYTEENABLE[0])
					begin
						nxt_st.ctrl.card_clock_stop_policy = AVS_WRITEDATA[`CTRL_POLICY_BIT];
						nxt_st.ctrl.card_supply_request    = AVS_WRITEDATA[`CTRL_VCC_LSB +: 3];
						nxt_st.ctrl.prog_supply_request    = AVS_WRITEDATA[`CTRL_VPP_LSB +: 3];
					end
				end
				`OFS_CLOCK_PM:
				begin
					if (AVS_BYTEENABLE[2])
						nxt_st.pm.clock_gate_enable = AVS_WRITEDATA[`PM_GATE_EN_BIT];
					if (AVS_BYTEENABLE[0])
						nxt_st.pm.clock_stop_or_slow_select = AVS_WRITEDATA[`PM_SLOW_SEL_BIT];
				end
				`OFS_FORCE_EVENT:
				begin
					if (AVS_BYTEENABLE[1])
					begin
						if (AVS_WRITEDATA[`FORCE_CAP_LSB +: 4] != 4'h0)
						begin
							nxt_st.caps        = card_caps_t'(AVS_WRITEDATA[`FORCE_CAP_LSB +: 4]);
							nxt_st.ctrl_enable = 1'b0;
						end
						// Retest wins over a force in the same write
						if (AVS_WRITEDATA[`FORCE_RETEST_BIT])
						begin
							nxt_st.caps        = pins.caps;
							nxt_st.ctrl_enable = 1'b1;
						end
					end
				end
				`OFS_EVT_CLEAR:
				begin
					if (AVS_BYTEENABLE[0])
						evt_clr = evt_t'(AVS_WRITEDATA[2:0]);
				end
				`OFS_EVT_ENABLE:
				begin
					if (AVS_BYTEENABLE[0])
						nxt_st.evt_enable = evt_t'(AVS_WRITEDATA[2:0]);
				end
				default:
				begin
					nxt_st.evt_enable = st_ff.evt_enable;
				end
			endcase
		end

		// ==========================================================
		// Event edges, access flag and interrupt
		nxt_st.access_prev  = pins.card_access;
		nxt_st.rate_prev    = rate_changed;
		nxt_st.bad_prev     = bad;
		evt_set.access      = pins.card_access && !st_ff.access_prev;
		evt_set.rate_change = rate_changed && !st_ff.rate_prev;
		evt_set.bad_request = bad && !st_ff.bad_prev;

		// Set beats the clear-on-read, so an access landing on the read is not lost
		if (rd && (AVS_ADDRESS == `OFS_CLOCK_PM))
		begin
			nxt_st.access_flag = 1'b0;
		end
		if (evt_set.access)
		begin
			nxt_st.access_flag = 1'b1;
		end

		// Status bits are sticky; a new event outranks a clear in the same cycle
		nxt_st.evt_status = (st_ff.evt_status & ~evt_clr) | evt_set;
		nxt_st.irq        = |(nxt_st.evt_status & st_ff.evt_enable);

		// ==========================================================
		// Power switch drive: a refused request leaves that rail off
		nxt_st.vcc_apply = `RST_SUPPLY;
		nxt_st.vpp_apply = `RST_SUPPLY;
		if (st_ff.ctrl_enable && ok_vcc)
		begin
			nxt_st.vcc_apply = st_ff.ctrl.card_supply_request;
			// Programming supply never stands on a card whose main supply is off
			if (ok_vpp && (st_ff.ctrl.card_supply_request != `SUP_OFF))
			begin
				nxt_st.vpp_apply = st_ff.ctrl.prog_supply_request;
			end
		end

		// ==========================================================
		// Card clock-run decision
		reduce_ok = pins.socket_idle && (st_ff.ctrl.card_clock_stop_policy || pins.host_stop_prep);
		// Without the gate the select bit has no say, so a reduction is a stop
		slow_sel  = st_ff.pm.clock_gate_enable && st_ff.pm.clock_stop_or_slow_select;
		unique case (st_ff.clk)
			CLK_RUN:
			begin
				if (reduce_ok)
				begin
					if (slow_sel)
						nxt_st.clk = CLK_SLOW;
					else
						nxt_st.clk = CLK_STOP;
				end
			end
			// A select change while reduced moves straight between stop and slow
			CLK_STOP:
			begin
				if (!reduce_ok)
					nxt_st.clk = CLK_RUN;
				else if (slow_sel)
					nxt_st.clk = CLK_SLOW;
			end
			CLK_SLOW:
			begin
				if (!reduce_ok)
					nxt_st.clk = CLK_RUN;
				else if (!slow_sel)
					nxt_st.clk = CLK_STOP;
			end
			default:
			begin
				nxt_st.clk = CLK_RUN;
			end
		endcase
	end

	always_ff @(posedge CORE_CLK)
	begin
		if (!RST_B)
		begin
			st_ff             <= '0;
			st_ff.bus         <= BUS_WAIT;
			st_ff.clk         <= CLK_RUN;
			st_ff.ctrl_enable <= 1'b1;
			st_ff.evt_status  <= `RST_EVT;
			st_ff.evt_enable  <= `RST_EVT;
		end
		else
		begin
			st_ff <= nxt_st;
		end
	end

	// ==========================================================
	// Outputs straight from flops
	assign AVS_READDATA    = st_ff.rdata;
	assign AVS_WAITREQUEST = st_ff.bus[0];
	assign VCC_APPLY       = st_ff.vcc_apply;
	assign VPP_APPLY       = st_ff.vpp_apply;
	assign CARD_CLK_STOP   = st_ff.clk[1];
	assign CARD_CLK_SLOW   = st_ff.clk[2];
	assign IRQ             = st_ff.irq;
endmodule // socket_power_clock_control

//--- test/socket_pcc_assertions.sv
// Concurrent checks on the socket power and card clock control ports.
// Assumes it is bound to socket_power_clock_control and sees only its ports.
`timescale 1ns/100ps
module socket_pcc_checker
(
	input wire logic        CORE_CLK,
	input wire logic        RST_B,
	input wire logic [5:0]  AVS_ADDRESS,
	input wire logic        AVS_READ,
	input wire logic        AVS_WRITE,
	input wire logic [31:0] AVS_READDATA,
	input wire logic        AVS_WAITREQUEST,
	input wire logic        SOCKET_IDLE,
	input wire logic [2:0]  VCC_APPLY,
	input wire logic [2:0]  VPP_APPLY,
	input wire logic        CARD_CLK_STOP,
	input wire logic        CARD_CLK_SLOW
);
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RST_B);

	// ==========================================================
	// Bus answer
	a_wait_one_cycle: assert property ($fell(AVS_WAITREQUEST) |=> AVS_WAITREQUEST)
		else $error("waitrequest low longer than one cycle");
	a_answer_next: assert property (($rose(AVS_READ) || $rose(AVS_WRITE)) |=> !AVS_WAITREQUEST)
		else $error("request not answered in the next cycle");
	a_idle_rdata_zero: assert property (AVS_WAITREQUEST |-> AVS_READDATA == 32'h0)
		else $error("read data not zero outside an answer");
	a_ctrl_rsvd_zero: assert property ((AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == 6'h10) |->
		(AVS_READDATA[31:8] == 24'h0 && !AVS_READDATA[3])) else $error("supply control reserved bits set");
	a_pm_rsvd_zero: assert property ((AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == 6'h20) |->
		(AVS_READDATA[31:26] == 6'h0 && AVS_READDATA[23:17] == 7'h0 && AVS_READDATA[15:1] == 15'h0))
		else $error("power management reserved bits set");

	// ==========================================================
	// Card clock and rails
	a_stop_slow_excl: assert property (!(CARD_CLK_STOP && CARD_CLK_SLOW))
		else $error("stop and slow requested together");
	a_busy_clock_runs: assert property ((!SOCKET_IDLE) [*5] |-> (!CARD_CLK_STOP && !CARD_CLK_SLOW))
		else $error("card clock reduced while socket busy");
	a_vcc_code_legal: assert property (VCC_APPLY inside {3'h0, [3'h2:3'h5]})
		else $error("reserved supply code applied");
	a_vpp_with_vcc: assert property (VPP_APPLY != 3'h0 |-> (VCC_APPLY != 3'h0 && VPP_APPLY <= 3'h5))
		else $error("programming supply applied without card supply");
endmodule // socket_pcc_checker

bind socket_power_clock_control socket_pcc_checker u_chk
(
	.CORE_CLK        (CORE_CLK),
	.RST_B           (RST_B),
	.AVS_ADDRESS     (AVS_ADDRESS),
	.AVS_READ        (AVS_READ),
	.AVS_WRITE       (AVS_WRITE),
	.AVS_READDATA    (AVS_READDATA),
	.AVS_WAITREQUEST (AVS_WAITREQUEST),
	.SOCKET_IDLE     (SOCKET_IDLE),
	.VCC_APPLY       (VCC_APPLY),
	.VPP_APPLY       (VPP_APPLY),
	.CARD_CLK_STOP   (CARD_CLK_STOP),
	.CARD_CLK_SLOW   (CARD_CLK_SLOW)
);

//--- test/card_clock_model.sv
// Card side clock: 160 ns nominal, sixteen times slower or held still on request.
// Assumes stop and slow come straight from the controller outputs.
`timescale 1ns/100ps
module card_clock_model
(
	input  wire logic stop,
	input  wire logic slow,
	output logic      card_clk
);
	// ==========================================================
	// Generator
	// Odd start offset keeps the card clock unrelated in phase to the core clock
	initial
	begin
		card_clk = 1'b0;
		#3.3;
		forever
		begin
			if (stop)
				#7;
			else
				#(slow ? 1280 : 80) card_clk = ~card_clk;
		end
	end
endmodule // card_clock_model

//--- test/testbench.sv
// Self-checking bench for the socket power and card clock control registers.
// Assumes the checker is bound in and the card clock model stands on the far side.
`timescale 1ns/100ps
module testbench;
	logic        clk;
	logic        rst_b;
	logic [5:0]  adr;
	logic        rd;
	logic        wr;
	logic [31:0] wdata;
	logic [3:0]  be;
	logic [31:0] rdata;
	logic [31:0] rq;
	logic        wait_req;
	logic        card_clk;
	logic        acc;
	logic        idle;
	logic        prep;
	logic [3:0]  caps;
	logic [2:0]  vcc;
	logic [2:0]  vpp;
	logic        stop;
	logic        slow;
	logic        irq;
	int          seed;
	int          mismatches;
	int          checked;

	socket_power_clock_control u_dut
	(
		.CORE_CLK(clk), .RST_B(rst_b), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
		.AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_req),
		.CARD_CLK(card_clk), .CARD_ACCESS(acc), .SOCKET_IDLE(idle), .HOST_CLK_STOP_PREP(prep),
		.CARD_CAPS(caps), .VCC_APPLY(vcc), .VPP_APPLY(vpp), .CARD_CLK_STOP(stop), .CARD_CLK_SLOW(slow), .IRQ(irq)
	);
	card_clock_model u_card (.stop(stop), .slow(slow), .card_clk(card_clk));

	// ==========================================================
	// Reference model and bus
	function automatic logic [2:0] vcc_e(logic [2:0] c, logic [3:0] k);
		return (c inside {[3'h2:3'h5]} && k[c - 2]) ? c : 3'h0;
	endfunction

	function automatic logic [2:0] vpp_e(logic [2:0] c, logic [3:0] k);
		return ((c == 3'h1 && (k[0] || k[1])) || (c inside {[3'h2:3'h5]} && k[c - 2])) ? c : 3'h0;
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
		end
	endtask

	// Request held until waitrequest is sampled low; released one edge before the next
	task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
		int n;
		n = 0;
		adr <= a;
		wdata <= d;
		rd <= !w;
		wr <= w;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (wait_req !== 1'b0 && n < 50);
		rq = rdata;
		if (n >= 50)
			chk(32'h1, 32'h0);
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rdc(input logic [5:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(rq, e);
	endtask

	task automatic pulse_access();
		acc <= 1'b1;
		repeat (3) @(posedge clk);
		acc <= 1'b0;
		repeat (8) @(posedge clk);
	endtask

	task summarize;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// ==========================================================
	// Clock, watchdog and scenarios
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	initial
	begin
		#100000;
		mismatches++;
		summarize();
	end

	initial
	begin
		logic [31:0] d;
		logic [31:0] k;
		logic        go;
		{rst_b, rd, wr, acc, idle, prep, adr, wdata, caps} = '0;
		seed = 86;
		be = 4'hF;
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		repeat (100) @(posedge clk);
		rdc(6'h10, 32'h0);
		rdc(6'h20, 32'h0);
		for (int i = 0; i < 8; i++)
		begin
			k = $random(seed);
			caps <= k[3:0];
			repeat (6) @(posedge clk);
			bus(1'b1, 6'h0C, 32'h4000);
			d = $random(seed);
			d[6:4] = 3'(i);
			bus(1'b1, 6'h10, d);
			rdc(6'h10, d & 32'hF7);
			repeat (2) @(posedge clk);
			chk(32'(vcc), 32'(vcc_e(d[6:4], k[3:0])));
			chk(32'(vpp), (vcc_e(d[6:4], k[3:0]) != 3'h0) ? 32'(vpp_e(d[2:0], k[3:0])) : 32'h0);
		end
		caps <= 4'hF;
		repeat (6) @(posedge clk);
		bus(1'b1, 6'h0C, 32'h4000);
		bus(1'b1, 6'h10, 32'h22);
		bus(1'b1, 6'h0C, 32'h400);
		bus(1'b1, 6'h10, 32'h33);
		rdc(6'h10, 32'h22);
		chk(32'(vcc), 32'h0);
		bus(1'b1, 6'h0C, 32'h4000);
		repeat (2) @(posedge clk);
		chk(32'(vcc), 32'h2);
		be <= 4'h1;
		bus(1'b1, 6'h20, 32'hFFFF_FFFF);
		be <= 4'hF;
		rdc(6'h20, 32'h1);
		bus(1'b1, 6'h20, 32'hFFFF_FFFF);
		rdc(6'h20, 32'h1_0001);
		pulse_access();
		rdc(6'h20, 32'h201_0001);
		rdc(6'h20, 32'h1_0001);
		bus(1'b1, 6'h3C, 32'hFFFF_FFFF);
		rdc(6'h3C, 32'h0);
		bus(1'b1, 6'h38, 32'h1);
		bus(1'b1, 6'h34, 32'h7);
		repeat (2) @(posedge clk);
		chk(32'(irq), 32'h0);
		pulse_access();
		chk(32'(irq), 32'h1);
		rdc(6'h30, 32'h1);
		bus(1'b1, 6'h38, 32'h0);
		repeat (2) @(posedge clk);
		chk(32'(irq), 32'h0);
		bus(1'b1, 6'h34, 32'h1);
		rdc(6'h30, 32'h0);
		idle <= 1'b1;
		for (int j = 0; j < 16; j++)
		begin
			bus(1'b1, 6'h10, {24'h0, j[0], 7'h22});
			bus(1'b1, 6'h20, {15'h0, j[2], 15'h0, j[3]});
			prep <= j[1];
			repeat (6) @(posedge clk);
			go = j[0] | j[1];
			chk(32'({stop, slow}), 32'({go & !(j[2] & j[3]), go & j[2] & j[3]}));
		end
		repeat (1000) @(posedge clk);
		rdc(6'h20, 32'h301_0001);
		rdc(6'h30, 32'h2);
		idle <= 1'b0;
		repeat (700) @(posedge clk);
		rdc(6'h20, 32'h1_0001);
		summarize();
	end
endmodule // testbench
